// file: rtl/timer16_pwm_regs.svh
// constants of the 16-bit timer with waveform mode
`ifndef TIMER16_PWM_REGS_SVH
`define TIMER16_PWM_REGS_SVH
`define TMR_RELOAD_VALUE     16'hfffc
`define TMR_SINGLE_CAP_VALUE 16'hfffd
`define TMR_COUNT_MAX        16'hffff
`define TMR_COUNT_RESET      16'h0000
`define TMR_CMP_RESET        16'h8000
`define TMR_DIV2_LAST        3'h1
`define TMR_DIV4_LAST        3'h3
`define TMR_DIV8_LAST        3'h7
`define TMR_FLAG_CAP1        0
`define TMR_FLAG_CAP2        1
`define TMR_FLAG_CMP1        2
`define TMR_FLAG_CMP2        3
`define TMR_FLAG_OVF         4
`define TMR_FLAG_COUNT       5
`endif

// file: rtl/timer16_pwm_pkg.sv
// types of the 16-bit timer with waveform mode
package timer16_pwm_pkg;
  typedef enum logic [1:0] {
    CLK_DIV4 = 2'b00,
    CLK_DIV2 = 2'b01,
    CLK_DIV8 = 2'b10,
    CLK_EXT  = 2'b11
  } clock_select_t;
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'b00,
    MODE_SINGLE  = 2'b01,
    MODE_WAVE    = 2'b10
  } mode_t;
endpackage

// file: rtl/timer16_pwm_lowpower_irq.sv
// 16-bit free-running timer with waveform mode, sleep handling and shared interrupt
`timescale 1ns/100ps
`default_nettype none
`include "timer16_pwm_regs.svh"
module timer16_pwm_lowpower_irq
  import timer16_pwm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        waveformMode,
  input  wire logic        singlePulseSelect,
  input  wire logic        waveformPinEnable,
  input  wire logic        levelAfterPulseMatch,
  input  wire logic        levelAfterPeriodMatch,
  input  wire logic [1:0]  timerClockSelect,
  input  wire logic        captureEdgeFirst,
  input  wire logic        captureEdgeSecond,
  input  wire logic        captureIrqEnable,
  input  wire logic        compareIrqEnable,
  input  wire logic        overflowIrqEnable,
  input  wire logic        cpuIrqMask,
  input  wire logic        cmpSel,
  input  wire logic        cmpHighWr,
  input  wire logic        cmpLowWr,
  input  wire logic        cmpLowRd,
  input  wire logic [7:0]  cmpWrData,
  input  wire logic        statusRd,
  input  wire logic        capFirstLowAccess,
  input  wire logic        capSecondLowAccess,
  input  wire logic        counterLowAccess,
  input  wire logic        capturePinFirst,
  input  wire logic        capturePinSecond,
  input  wire logic        extClk,
  input  wire logic        waitMode,
  input  wire logic        haltMode,
  input  wire logic        haltWakeIrq,
  output logic             waveformPin,
  output logic             captureFlagFirst,
  output logic             captureFlagSecond,
  output logic             compareMatchFlagFirst,
  output logic             compareMatchFlagSecond,
  output logic             overflowFlag,
  output logic [15:0]      counterValue,
  output logic [15:0]      captureValueFirst,
  output logic [15:0]      captureValueSecond,
  output logic             timerIrq,
  output logic             wakeFromWait
);

  mode_t       mode_q;
  logic [2:0]  div_q;
  logic        extPrev_q;
  logic        capPrev1_q;
  logic        capPrev2_q;
  logic [15:0] counter_q;
  logic [15:0] pulseShadow_q;
  logic [15:0] periodShadow_q;
  logic [15:0] pulseActive_q;
  logic [15:0] periodActive_q;
  logic [1:0]  inhibit_q;
  logic [1:0]  haltArm_q;
  logic        pinLatch_q;
  logic [15:0] cap1_q;
  logic [15:0] cap2_q;
  logic [`TMR_FLAG_COUNT-1:0] flag_q;
  logic [`TMR_FLAG_COUNT-1:0] clrArm_q;
  logic [`TMR_FLAG_COUNT-1:0] flagSet;
  logic [`TMR_FLAG_COUNT-1:0] flagClr;
  logic        tick;
  logic        pulMatch;
  logic        perMatch;
  logic        edge1;
  logic        edge2;
  logic        singleStart;
  logic        irqD;
  logic        pin_q;
  logic        irq_q;
  logic        wake_q;

  function automatic logic cmpHit(input logic [15:0] cnt, input logic [15:0] val,
                                  input logic inhibit);
    cmpHit = (cnt == val) && !inhibit;
  endfunction

  function automatic logic edgeSeen(input logic now, input logic prev, input logic rising);
    edgeSeen = rising ? (now && !prev) : (!now && prev);
  endfunction

  // waveform mode takes priority over single pulse mode
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      mode_q <= MODE_COMPARE;
    else
    begin
      case ({waveformMode, singlePulseSelect})
        2'b10, 2'b11: mode_q <= MODE_WAVE;
        2'b01:        mode_q <= MODE_SINGLE;
        2'b00:        mode_q <= MODE_COMPARE;
        default:      mode_q <= MODE_COMPARE;
      endcase
    end
  end

  // prescaler and external clock edge; both stop in deep sleep
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_q     <= 3'h0;
      extPrev_q <= 1'b0;
    end
    else if (!haltMode)
    begin
      div_q     <= div_q + 3'h1;
      extPrev_q <= extClk;
    end
  end

  always_comb
  begin
    case (clock_select_t'(timerClockSelect))
      CLK_DIV4: tick = (div_q[1:0] == 2'(`TMR_DIV4_LAST));
      CLK_DIV2: tick = (div_q[0] == 1'(`TMR_DIV2_LAST));
      CLK_DIV8: tick = (div_q == `TMR_DIV8_LAST);
      CLK_EXT:  tick = extClk && !extPrev_q;
      default:  tick = 1'b0;
    endcase
    if (haltMode)
      tick = 1'b0;
  end

  // matches are judged once per tick, on the count about to be left
  assign pulMatch = tick && mode_q != MODE_COMPARE ? cmpHit(counter_q, pulseActive_q, inhibit_q[0])
                  : tick && cmpHit(counter_q, pulseActive_q, inhibit_q[0]);
  assign perMatch = tick && mode_q == MODE_WAVE
                 && cmpHit(counter_q, periodActive_q, inhibit_q[1]);
  assign edge1 = !haltMode && edgeSeen(capturePinFirst, capPrev1_q, captureEdgeFirst);
  assign edge2 = !haltMode && edgeSeen(capturePinSecond, capPrev2_q, captureEdgeSecond);
  assign singleStart = edge1 && mode_q == MODE_SINGLE;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      capPrev1_q <= 1'b0;
      capPrev2_q <= 1'b0;
    end
    else
    begin
      capPrev1_q <= capturePinFirst;
      capPrev2_q <= capturePinSecond;
    end
  end

  // counter: reload on period match, start of single pulse, else count and wrap
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      counter_q <= `TMR_COUNT_RESET;
    else if (perMatch || singleStart)
      counter_q <= `TMR_RELOAD_VALUE;
    else if (tick)
      counter_q <= counter_q + 16'h0001;
  end

  // software side of the compare values; high byte suspends the channel
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pulseShadow_q  <= `TMR_CMP_RESET;
      periodShadow_q <= `TMR_CMP_RESET;
      inhibit_q      <= 2'b00;
    end
    else
    begin
      if (cmpHighWr && !cmpSel)
        pulseShadow_q[15:8] <= cmpWrData;
      if (cmpLowWr && !cmpSel)
        pulseShadow_q[7:0] <= cmpWrData;
      if (cmpHighWr && cmpSel)
        periodShadow_q[15:8] <= cmpWrData;
      if (cmpLowWr && cmpSel)
        periodShadow_q[7:0] <= cmpWrData;
      if (cmpHighWr)
        inhibit_q[cmpSel] <= 1'b1;
      else if (cmpLowWr)
        inhibit_q[cmpSel] <= 1'b0;
    end
  end

  // in waveform mode the working copies change only at the period boundary,
  // so a half-written period value never shapes a pulse; a half-written pulse value can be copied
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pulseActive_q  <= `TMR_CMP_RESET;
      periodActive_q <= `TMR_CMP_RESET;
    end
    else if (mode_q != MODE_WAVE || perMatch)
    begin
      pulseActive_q  <= pulseShadow_q;
      periodActive_q <= periodShadow_q;
    end
  end

  // pin latch: period level wins when both matches coincide
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pinLatch_q <= 1'b0;
    else if (perMatch || singleStart)
      pinLatch_q <= levelAfterPeriodMatch;
    else if (pulMatch)
      pinLatch_q <= levelAfterPulseMatch;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pin_q <= 1'b0;
    else if (!haltMode)
      pin_q <= waveformPinEnable && pinLatch_q;
  end

  // event sources for the five flags
  always_comb
  begin
    flagSet = '0;
    flagSet[`TMR_FLAG_CAP1] = perMatch || (edge1 && mode_q != MODE_WAVE)
                           || (haltWakeIrq && haltArm_q[0]);
    flagSet[`TMR_FLAG_CAP2] = edge2 || (haltWakeIrq && haltArm_q[1]);
    flagSet[`TMR_FLAG_CMP1] = pulMatch && mode_q == MODE_COMPARE;
    flagSet[`TMR_FLAG_CMP2] = tick && mode_q != MODE_WAVE
                           && cmpHit(counter_q, periodActive_q, inhibit_q[1]);
    flagSet[`TMR_FLAG_OVF]  = tick && counter_q == `TMR_COUNT_MAX
                           && !perMatch && !singleStart;
    flagClr = '0;
    flagClr[`TMR_FLAG_CAP1] = capFirstLowAccess;
    flagClr[`TMR_FLAG_CAP2] = capSecondLowAccess;
    flagClr[`TMR_FLAG_CMP1] = (cmpLowWr || cmpLowRd) && !cmpSel;
    flagClr[`TMR_FLAG_CMP2] = (cmpLowWr || cmpLowRd) && cmpSel;
    flagClr[`TMR_FLAG_OVF]  = counterLowAccess;
  end

  // two-step clear: status read with flag seen, then the low-byte access;
  // a new event in the clearing cycle keeps the flag set
  genvar g;
  generate
    for (g = 0; g < `TMR_FLAG_COUNT; g++)
    begin : gFlag
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          flag_q[g]   <= 1'b0;
          clrArm_q[g] <= 1'b0;
        end
        else
        begin
          if (flagSet[g])
            flag_q[g] <= 1'b1;
          else if (clrArm_q[g] && flagClr[g])
            flag_q[g] <= 1'b0;
          if (statusRd && flag_q[g])
            clrArm_q[g] <= 1'b1;
          else if (flagClr[g])
            clrArm_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // captures; in deep sleep an edge only arms, the value is taken at wake
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cap1_q    <= `TMR_COUNT_RESET;
      cap2_q    <= `TMR_COUNT_RESET;
      haltArm_q <= 2'b00;
    end
    else
    begin
      if (haltMode && edgeSeen(capturePinFirst, capPrev1_q, captureEdgeFirst)
          && mode_q == MODE_COMPARE)
        haltArm_q[0] <= 1'b1;
      else if (haltWakeIrq)
        haltArm_q[0] <= 1'b0;
      if (haltMode && edgeSeen(capturePinSecond, capPrev2_q, captureEdgeSecond))
        haltArm_q[1] <= 1'b1;
      else if (haltWakeIrq)
        haltArm_q[1] <= 1'b0;
      if (singleStart)
        cap1_q <= `TMR_SINGLE_CAP_VALUE;
      else if ((edge1 && mode_q == MODE_COMPARE) || (haltWakeIrq && haltArm_q[0]))
        cap1_q <= counter_q;
      if (edge2 || (haltWakeIrq && haltArm_q[1]))
        cap2_q <= counter_q;
    end
  end

  // one shared request; only light sleep is left by it
  assign irqD = !cpuIrqMask && (
                (captureIrqEnable && (flag_q[`TMR_FLAG_CAP1] || flag_q[`TMR_FLAG_CAP2]))
             || (compareIrqEnable && (flag_q[`TMR_FLAG_CMP1] || flag_q[`TMR_FLAG_CMP2]))
             || (overflowIrqEnable && flag_q[`TMR_FLAG_OVF]));

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_q  <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      irq_q  <= irqD;
      wake_q <= waitMode && irqD;
    end
  end

  assign waveformPin            = pin_q;
  assign captureFlagFirst       = flag_q[`TMR_FLAG_CAP1];
  assign captureFlagSecond      = flag_q[`TMR_FLAG_CAP2];
  assign compareMatchFlagFirst  = flag_q[`TMR_FLAG_CMP1];
  assign compareMatchFlagSecond = flag_q[`TMR_FLAG_CMP2];
  assign overflowFlag           = flag_q[`TMR_FLAG_OVF];
  assign counterValue           = counter_q;
  assign captureValueFirst      = cap1_q;
  assign captureValueSecond     = cap2_q;
  assign timerIrq               = irq_q;
  assign wakeFromWait           = wake_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_reload;
    perMatch |=> counterValue == `TMR_RELOAD_VALUE;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload after period match");

  property p_period_sets_capture;
    perMatch |=> captureFlagFirst;
  endproperty
  a_period_sets_capture: assert property (p_period_sets_capture)
    else $error("period match did not set first capture flag");

  property p_no_compare_flags;
    mode_q == MODE_WAVE |=> !$rose(compareMatchFlagFirst) && !$rose(compareMatchFlagSecond);
  endproperty
  a_no_compare_flags: assert property (p_no_compare_flags)
    else $error("compare flag set in waveform mode");

  property p_pulse_level;
    (pulMatch && !perMatch && !singleStart && waveformPinEnable) ##1
      (waveformPinEnable && !haltMode)
      |=> waveformPin == $past(levelAfterPulseMatch, 2);
  endproperty
  a_pulse_level: assert property (p_pulse_level)
    else $error("pin did not take pulse level");

  property p_period_level;
    (perMatch && waveformPinEnable) ##1 (waveformPinEnable && !haltMode)
      |=> waveformPin == $past(levelAfterPeriodMatch, 2);
  endproperty
  a_period_level: assert property (p_period_level)
    else $error("pin did not take period level");

  property p_inhibit;
    (cmpHighWr && cmpSel) ##1 (!cmpLowWr)[*2] |-> !$past(perMatch);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("compare ran while suspended");

  property p_halt_freeze;
    haltMode && $past(haltMode) && !$past(perMatch) |-> $stable(counterValue);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) else $error("counter moved in deep sleep");

  property p_shared_irq;
    (!cpuIrqMask && overflowIrqEnable && overflowFlag) |=> timerIrq;
  endproperty
  a_shared_irq: assert property (p_shared_irq) else $error("overflow did not raise interrupt");

  property p_irq_masked;
    cpuIrqMask |=> !timerIrq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt while masked");

  property p_wait_wake;
    (waitMode && irqD) |=> wakeFromWait && timerIrq;
  endproperty
  a_wait_wake: assert property (p_wait_wake) else $error("no wake from light sleep");

  property p_overflow;
    (tick && counterValue == `TMR_COUNT_MAX && !perMatch && !singleStart)
      |=> overflowFlag && counterValue == `TMR_COUNT_RESET;
  endproperty
  a_overflow: assert property (p_overflow) else $error("wrap without overflow flag");

  property p_hold_buffer;
    (mode_q == MODE_WAVE && !perMatch) |=> $stable(pulseActive_q) && $stable(periodActive_q);
  endproperty
  a_hold_buffer: assert property (p_hold_buffer)
    else $error("compare value changed inside a period");

endmodule
`default_nettype wire

// file: test/pin_partner.sv
// model of the circuitry on the capture, external clock and waveform pins
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
  input  wire logic        clk,
  input  wire logic        waveformPin,
  output logic             capturePinFirst,
  output logic             capturePinSecond,
  output logic             extClk,
  output logic [15:0]      highLen,
  output logic [15:0]      periodLen
);
  logic        prevPin;
  logic [15:0] highCnt;
  logic [15:0] periodCnt;

  initial
  begin
    {capturePinFirst, capturePinSecond, extClk, prevPin} = '0;
    {highLen, periodLen, highCnt, periodCnt} = '0;
  end

  function automatic void set_pin(input int which, input logic v);
    if (which == 0)
      capturePinFirst = v;
    else if (which == 1)
      capturePinSecond = v;
    else
      extClk = v;
  endfunction

  // two cycles high and low so the synchronous sampling sees each level
  task automatic pulse(input int which);
    set_pin(which, 1'b1);
    repeat (2) @(negedge clk);
    set_pin(which, 1'b0);
    repeat (2) @(negedge clk);
  endtask

  // lengths of the last high phase and the last full period, in clocks
  always @(posedge clk)
  begin
    prevPin <= waveformPin;
    if (waveformPin && !prevPin)
    begin
      periodLen <= periodCnt;
      periodCnt <= 16'h0001;
      highCnt   <= 16'h0001;
    end
    else
    begin
      periodCnt <= periodCnt + 16'h0001;
      if (waveformPin)
        highCnt <= highCnt + 16'h0001;
    end
    if (!waveformPin && prevPin)
      highLen <= highCnt;
  end
endmodule
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the 16-bit timer in waveform mode
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module testbench;
  import timer16_pwm_pkg::*;
  logic clk, nrst, waveformMode, singlePulseSelect, waveformPinEnable;
  logic levelAfterPulseMatch, levelAfterPeriodMatch, captureEdgeFirst, captureEdgeSecond;
  logic captureIrqEnable, compareIrqEnable, overflowIrqEnable, cpuIrqMask, cmpSel;
  logic cmpHighWr, cmpLowWr, cmpLowRd, statusRd, capFirstLowAccess, capSecondLowAccess;
  logic counterLowAccess, waitMode, haltMode, haltWakeIrq, capturePinFirst;
  logic capturePinSecond, extClk, waveformPin, captureFlagFirst, captureFlagSecond;
  logic compareMatchFlagFirst, compareMatchFlagSecond, overflowFlag, timerIrq, wakeFromWait;
  logic [1:0]  timerClockSelect;
  logic [7:0]  cmpWrData;
  logic [15:0] counterValue, captureValueFirst, captureValueSecond, held, highLen, periodLen;
  int          failures = 0;
  int          check_count = 0;
  int          n;
  clock_select_t sels [3] = '{CLK_DIV4, CLK_DIV2, CLK_DIV8};
  int          divs [3] = '{4, 2, 8};

  timer16_pwm_lowpower_irq dut_u (.clk, .nrst, .waveformMode, .singlePulseSelect,
    .waveformPinEnable, .levelAfterPulseMatch, .levelAfterPeriodMatch, .timerClockSelect,
    .captureEdgeFirst, .captureEdgeSecond, .captureIrqEnable, .compareIrqEnable,
    .overflowIrqEnable, .cpuIrqMask, .cmpSel, .cmpHighWr, .cmpLowWr, .cmpLowRd, .cmpWrData,
    .statusRd, .capFirstLowAccess, .capSecondLowAccess, .counterLowAccess, .capturePinFirst,
    .capturePinSecond, .extClk, .waitMode, .haltMode, .haltWakeIrq, .waveformPin,
    .captureFlagFirst, .captureFlagSecond, .compareMatchFlagFirst, .compareMatchFlagSecond,
    .overflowFlag, .counterValue, .captureValueFirst, .captureValueSecond, .timerIrq,
    .wakeFromWait);

  pin_partner partner_u (.clk, .waveformPin, .capturePinFirst, .capturePinSecond, .extClk,
    .highLen, .periodLen);

  always #20 clk = ~clk;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic strobe(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  // a hang here counts as a mismatch and closes the run
  task automatic wait_for(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 3000)
    begin
      failures++;
      $display("CHECK FAILED wait expected %0h seen %0h", v, s);
      give_verdict();
    end
  endtask

  task automatic cmp_write(input logic sel, input logic [15:0] v);
    cmpSel = sel;
    cmpWrData = v[15:8];
    strobe(cmpHighWr);
    cmpWrData = v[7:0];
    strobe(cmpLowWr);
  endtask

  task automatic clear_first();
    strobe(statusRd);
    strobe(capFirstLowAccess);
    @(negedge clk);
  endtask

  initial
  begin
    {nrst, waveformMode, singlePulseSelect, waveformPinEnable, levelAfterPulseMatch} = '0;
    {levelAfterPeriodMatch, captureEdgeFirst, captureEdgeSecond, captureIrqEnable} = '0;
    {compareIrqEnable, overflowIrqEnable, cpuIrqMask, cmpSel, cmpHighWr, cmpLowWr} = '0;
    {cmpLowRd, statusRd, capFirstLowAccess, capSecondLowAccess, counterLowAccess} = '0;
    {waitMode, haltMode, haltWakeIrq, timerClockSelect, cmpWrData} = '0;
    clk = 1'b0;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    `CHK("counter", 16'h0000, counterValue)
    `CHK("outs", 7'h00, {waveformPin, captureFlagFirst, captureFlagSecond,
      compareMatchFlagFirst, compareMatchFlagSecond, overflowFlag, timerIrq})
    for (int i = 0; i < 3; i++)
    begin
      timerClockSelect = sels[i];
      repeat (8) @(negedge clk);
      held = counterValue;
      repeat (48) @(negedge clk);
      `CHK("rate", 16'(48 / divs[i]), 16'(counterValue - held))
    end
    timerClockSelect = CLK_EXT;
    held = counterValue;
    repeat (5) partner_u.pulse(2);
    `CHK("ext", 16'h0005, 16'(counterValue - held))
    // compare values are already tick counts less five
    timerClockSelect = CLK_DIV2;
    cmp_write(1'b1, 16'h0200);
    cmp_write(1'b0, 16'h01f0);
    {levelAfterPulseMatch, levelAfterPeriodMatch} = 2'h2;
    {waveformPinEnable, singlePulseSelect, waveformMode, compareIrqEnable} = 4'hf;
    wait_for(captureFlagFirst, 1'b1);
    `CHK("reload", 16'hfffc, counterValue)
    `CHK("cmpflags", 2'h0, {compareMatchFlagFirst, compareMatchFlagSecond})
    `CHK("noirq", 1'b0, timerIrq)
    strobe(capFirstLowAccess);
    `CHK("access_only", 1'b1, captureFlagFirst)
    clear_first();
    `CHK("cleared1", 1'b0, captureFlagFirst)
    repeat (2)
    begin
      wait_for(waveformPin, 1'b1);
      wait_for(waveformPin, 1'b0);
    end
    `CHK("high", 16'd32, highLen)
    `CHK("period", 16'd1034, periodLen)
    captureIrqEnable = 1'b1;
    wait_for(captureFlagFirst, 1'b1);
    repeat (2) @(negedge clk);
    `CHK("irq", 1'b1, timerIrq)
    waitMode = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("wake", 1'b1, wakeFromWait)
    cpuIrqMask = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("mask", 1'b0, timerIrq)
    waitMode = 1'b0;
    captureEdgeSecond = 1'b1;
    partner_u.pulse(1);
    `CHK("cap2", 1'b1, captureFlagSecond)
    strobe(statusRd);
    strobe(capSecondLowAccess);
    @(negedge clk);
    `CHK("cleared2", 1'b0, captureFlagSecond)
    haltMode = 1'b1;
    repeat (2) @(negedge clk);
    held = counterValue;
    partner_u.pulse(1);
    repeat (20) @(negedge clk);
    `CHK("frozen", held, counterValue)
    `CHK("armed", 1'b0, captureFlagSecond)
    strobe(haltWakeIrq);
    @(negedge clk);
    `CHK("wake_cap", 1'b1, captureFlagSecond)
    `CHK("wake_val", held, captureValueSecond)
    haltMode = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("resume", 1'b1, counterValue != held)
    levelAfterPeriodMatch = 1'b1;
    repeat (1100) @(negedge clk);
    n = 0;
    repeat (1100)
    begin
      @(negedge clk);
      n += (waveformPin !== 1'b1);
    end
    `CHK("steady", 0, n)
    clear_first();
    wait_for(captureFlagFirst, 1'b1);
    clear_first();
    captureEdgeFirst = 1'b1;
    partner_u.pulse(0);
    `CHK("cap1_off", 1'b0, captureFlagFirst)
    cmpSel = 1'b1;
    cmpWrData = 8'h02;
    strobe(cmpHighWr);
    repeat (1100) @(negedge clk);
    `CHK("suspend", 1'b0, captureFlagFirst)
    `CHK("no_reload", 1'b1, counterValue > 16'h0200)
    give_verdict();
  end
endmodule
`default_nettype wire
